// file: design/ecs_snapshot_bank.sv
// Purpose: APB bank of read-only E1 error counter snapshots
// Assumes: event inputs are one-cycle pulses from logic on clk
// Notes: snapshots refresh as one group on manual or timed update
`timescale 1ns/100ps

module ecs_snapshot_bank #(
	parameter longint AUTO_CYCLES = ecs_pkg::AUTO_PERIOD_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ecs_pkg::ECS_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire ecs_pkg::ecs_events_s events,
	output logic snapshot_done
);
	import ecs_pkg::*;

	localparam int TW = $clog2(AUTO_CYCLES + 1);
	localparam logic [TW-1:0] AUTO_LAST = TW'(AUTO_CYCLES - 1);

	ecs_counts_s running;
	ecs_counts_s snap;
	logic [1:0] control;
	logic manual_prev;
	logic [TW-1:0] auto_timer;
	logic auto_tick;
	logic transfer;
	logic access;
	logic wr_take;
	logic [7:0] index;
	logic addr_ok;
	logic [7:0] next_rdata;

	// ----------------------------------------------------------------
	// running counters
	// ----------------------------------------------------------------
	// one counter per source
	// crc-4 errors on the receive side
	ecs_event_counter #(
		.WIDTH(W_CRC4)
	) u_crc4 (
		.clk(clk),
		.rst_n(rst_n),
		.event_in(events.crc4),
		.transfer(transfer),
		.count(running.crc4)
	);

	// framing pattern bit errors
	ecs_event_counter #(
		.WIDTH(W_FRAMING)
	) u_framing (
		.clk(clk),
		.rst_n(rst_n),
		.event_in(events.framing),
		.transfer(transfer),
		.count(running.framing)
	);

	// alignment position changes, small field saturates early
	ecs_event_counter #(
		.WIDTH(W_ALIGN)
	) u_align (
		.clk(clk),
		.rst_n(rst_n),
		.event_in(events.align_change),
		.transfer(transfer),
		.count(running.align_change)
	);

	// losses of basic frame synchronization
	ecs_event_counter #(
		.WIDTH(W_FRAME_LOSS)
	) u_frame_loss (
		.clk(clk),
		.rst_n(rst_n),
		.event_in(events.frame_loss),
		.transfer(transfer),
		.count(running.frame_loss)
	);

	// pattern detector bit errors
	ecs_event_counter #(
		.WIDTH(W_PATTERN)
	) u_pattern (
		.clk(clk),
		.rst_n(rst_n),
		.event_in(events.pattern),
		.transfer(transfer),
		.count(running.pattern)
	);

	// line code violations, whichever decoding is selected
	ecs_event_counter #(
		.WIDTH(W_CODE_VIOL)
	) u_code_viol (
		.clk(clk),
		.rst_n(rst_n),
		.event_in(events.code_violation),
		.transfer(transfer),
		.count(running.code_violation)
	);

	// nt crc errors
	ecs_event_counter #(
		.WIDTH(W_NT_CRC)
	) u_nt_crc (
		.clk(clk),
		.rst_n(rst_n),
		.event_in(events.nt_crc),
		.transfer(transfer),
		.count(running.nt_crc)
	);

	// far-end block errors
	ecs_event_counter #(
		.WIDTH(W_FAR_BLOCK)
	) u_far_block (
		.clk(clk),
		.rst_n(rst_n),
		.event_in(events.far_block),
		.transfer(transfer),
		.count(running.far_block)
	);

	// nt far-end block errors
	ecs_event_counter #(
		.WIDTH(W_NT_FAR)
	) u_nt_far (
		.clk(clk),
		.rst_n(rst_n),
		.event_in(events.nt_far_block),
		.transfer(transfer),
		.count(running.nt_far_block)
	);

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// access phase ends one cycle after it starts
	assign access = psel && penable;
	assign wr_take = access && pready && pwrite;
	assign index = {2'h0, paddr[ECS_AW-1:IDX_SHIFT]};
	assign addr_ok = (paddr[IDX_SHIFT-1:0] == 2'h0) && (index <= IDX_CONTROL);

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	// software-written trigger and auto enable bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			control <= CTRL_RESET;
		end else if (wr_take && addr_ok && index == IDX_CONTROL) begin
			control <= pwdata[1:0];
		end
	end

	// previous trigger value for edge detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			manual_prev <= 1'b0;
		end else begin
			manual_prev <= control[CTRL_MANUAL_BIT];
		end
	end

	// ----------------------------------------------------------------
	// one second timer
	// ----------------------------------------------------------------
	// periodic auto tick
	// restarts when disabled so the first tick is a full period away
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			auto_timer <= '0;
		end else if (!control[CTRL_AUTO_BIT] || auto_timer == AUTO_LAST) begin
			auto_timer <= '0;
		end else begin
			auto_timer <= auto_timer + 1'b1;
		end
	end
	assign auto_tick = control[CTRL_AUTO_BIT] && (auto_timer == AUTO_LAST);

	assign transfer = (control[CTRL_MANUAL_BIT] && !manual_prev) || auto_tick;

	// ----------------------------------------------------------------
	// snapshot group
	// ----------------------------------------------------------------
	// whole group loads at once
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			snap <= '0;
		end else if (transfer) begin
			snap <= running;
		end
	end

	// pulse on the same edge as the group loads
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			snapshot_done <= 1'b0;
		end else begin
			snapshot_done <= transfer;
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	// reserved bits read as zero
	always_comb begin
		next_rdata = 8'h00;
		if (index == IDX_CRC4_LOW) begin
			next_rdata = snap.crc4[7:0];
		end else if (index == IDX_CRC4_HIGH) begin
			next_rdata = {2'h0, snap.crc4[9:8], 4'h0};
		end else if (index == IDX_FRAMING_LOW) begin
			next_rdata = snap.framing[7:0];
		end else if (index == IDX_FRAMING_HIGH) begin
			next_rdata = {4'h0, snap.framing[11:8]};
		end else if (index == IDX_ALIGN_CHANGE) begin
			next_rdata = {5'h00, snap.align_change};
		end else if (index == IDX_FRAME_LOSS) begin
			next_rdata = {4'h0, snap.frame_loss};
		end else if (index == IDX_PATTERN_LOW) begin
			next_rdata = snap.pattern[7:0];
		end else if (index == IDX_PATTERN_HIGH) begin
			next_rdata = snap.pattern[15:8];
		end else if (index == IDX_CODE_VIOL_LOW) begin
			next_rdata = snap.code_violation[7:0];
		end else if (index == IDX_CODE_VIOL_HIGH) begin
			next_rdata = snap.code_violation[15:8];
		end else if (index == IDX_NT_CRC_LOW) begin
			next_rdata = snap.nt_crc[7:0];
		end else if (index == IDX_NT_CRC_HIGH) begin
			next_rdata = {2'h0, snap.nt_crc[9:8], 4'h0};
		end else if (index == IDX_FAR_BLOCK_LOW) begin
			next_rdata = snap.far_block[7:0];
		end else if (index == IDX_FAR_BLOCK_HIGH) begin
			next_rdata = {2'h0, snap.far_block[9:8], 4'h0};
		end else if (index == IDX_NT_FAR_LOW) begin
			next_rdata = snap.nt_far_block[7:0];
		end else if (index == IDX_NT_FAR_HIGH) begin
			next_rdata = {2'h0, snap.nt_far_block[9:8], 4'h0};
		end else if (index == IDX_CONTROL) begin
			next_rdata = {6'h00, control};
		end
	end

	// ----------------------------------------------------------------
	// apb answer
	// ----------------------------------------------------------------
	// one wait state keeps every answer straight from a flip-flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (access && !pready) begin
			pready <= 1'b1;
			// snapshots are read-only, so a write to them is an error
			pslverr <= !addr_ok || (pwrite && index != IDX_CONTROL);
			prdata <= (addr_ok && !pwrite) ? {24'h00_0000, next_rdata}
				: 32'h0000_0000;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
	end

endmodule : ecs_snapshot_bank

// file: design/ecs_pkg.sv
// Purpose: shared constants and types for the error counter snapshot bank
// Assumes: 100 MHz clock, APB with 32-bit data and byte addresses
// Notes: register index times four gives the byte address
package ecs_pkg;

	// ----------------------------------------------------------------
	// address map
	// ----------------------------------------------------------------
	localparam int ECS_AW = 8;
	localparam logic [7:0] IDX_CRC4_LOW = 8'h00;
	localparam logic [7:0] IDX_CRC4_HIGH = 8'h01;
	localparam logic [7:0] IDX_FRAMING_LOW = 8'h02;
	localparam logic [7:0] IDX_FRAMING_HIGH = 8'h03;
	localparam logic [7:0] IDX_ALIGN_CHANGE = 8'h04;
	localparam logic [7:0] IDX_FRAME_LOSS = 8'h05;
	localparam logic [7:0] IDX_PATTERN_LOW = 8'h06;
	localparam logic [7:0] IDX_PATTERN_HIGH = 8'h07;
	localparam logic [7:0] IDX_CODE_VIOL_LOW = 8'h08;
	localparam logic [7:0] IDX_CODE_VIOL_HIGH = 8'h09;
	localparam logic [7:0] IDX_NT_CRC_LOW = 8'h0a;
	localparam logic [7:0] IDX_NT_CRC_HIGH = 8'h0b;
	localparam logic [7:0] IDX_FAR_BLOCK_LOW = 8'h0c;
	localparam logic [7:0] IDX_FAR_BLOCK_HIGH = 8'h0d;
	localparam logic [7:0] IDX_NT_FAR_LOW = 8'h0e;
	localparam logic [7:0] IDX_NT_FAR_HIGH = 8'h0f;
	localparam logic [7:0] IDX_CONTROL = 8'h10;
	localparam int IDX_SHIFT = 2;

	// control register fields
	localparam int CTRL_AUTO_BIT = 0;
	localparam int CTRL_MANUAL_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// ----------------------------------------------------------------
	// counter widths and timing
	// ----------------------------------------------------------------
	localparam int W_CRC4 = 10;
	localparam int W_FRAMING = 12;
	localparam int W_ALIGN = 3;
	localparam int W_FRAME_LOSS = 4;
	localparam int W_PATTERN = 16;
	localparam int W_CODE_VIOL = 16;
	localparam int W_NT_CRC = 10;
	localparam int W_FAR_BLOCK = 10;
	localparam int W_NT_FAR = 10;
	localparam int N_EVENTS = 9;

	localparam longint CLK_HZ = 100000000;
	localparam longint AUTO_PERIOD_S = 1;
	localparam longint AUTO_PERIOD_CYCLES = CLK_HZ * AUTO_PERIOD_S;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [W_CRC4-1:0] crc4;
		logic [W_FRAMING-1:0] framing;
		logic [W_ALIGN-1:0] align_change;
		logic [W_FRAME_LOSS-1:0] frame_loss;
		logic [W_PATTERN-1:0] pattern;
		logic [W_CODE_VIOL-1:0] code_violation;
		logic [W_NT_CRC-1:0] nt_crc;
		logic [W_FAR_BLOCK-1:0] far_block;
		logic [W_NT_FAR-1:0] nt_far_block;
	} ecs_counts_s;

	typedef struct packed {
		logic crc4;
		logic framing;
		logic align_change;
		logic frame_loss;
		logic pattern;
		logic code_violation;
		logic nt_crc;
		logic far_block;
		logic nt_far_block;
	} ecs_events_s;

endpackage : ecs_pkg

// file: design/ecs_event_counter.sv
// Purpose: one running event counter that restarts on transfer
// Assumes: event and transfer strobes come from logic on clk
// Notes: saturates at all ones rather than wrapping
`timescale 1ns/100ps
module ecs_event_counter #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic event_in,
	input wire logic transfer,
	output logic [WIDTH-1:0] count
);

	// ----------------------------------------------------------------
	// counting
	// ----------------------------------------------------------------
	// restart on transfer
	// an event in the transfer cycle starts the new interval at one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (transfer) begin
			count <= {{(WIDTH-1){1'b0}}, event_in};
		end else if (event_in && !(&count)) begin
			count <= count + 1'b1; // saturate: a wrap would read as few errors
		end
	end

endmodule : ecs_event_counter

// file: test/ecs_snapshot_bank_props.sv
// Purpose: port checks for the error counter snapshot bank
// Assumes: the master holds each APB request until pready
// Notes: the timed period is judged only after a first timed refresh
`timescale 1ns/100ps
module ecs_snapshot_bank_props #(
	parameter longint AUTO_CYCLES = 20
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ecs_pkg::ECS_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire ecs_pkg::ecs_events_s events,
	input wire logic snapshot_done
);
	import ecs_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// shadow of the control register and refresh spacing
	// ------------------------------------------------------------
	logic trig_q;
	logic auto_q;
	logic primed;
	logic [1:0] man_dly;
	longint since;
	wire ack = psel && penable && pready;
	wire rd = ack && !pwrite;
	wire ctl_wr = ack && pwrite && paddr == 8'h40;
	wire man_rise = ctl_wr && pwdata[1] && !trig_q;
	// control bits as the completed writes leave them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_q <= 1'b0;
			auto_q <= 1'b0;
		end else if (ctl_wr) begin
			trig_q <= pwdata[1];
			auto_q <= pwdata[0];
		end
	end
	// a control write can restart the timer or trigger an off-phase refresh, so each one drops primed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			since <= 0;
			primed <= 1'b0;
			man_dly <= 2'h0;
		end else begin
			since <= snapshot_done ? 0 : since + 1;
			man_dly <= {man_dly[0], man_rise};
			// a manual refresh is off the timer phase, so it never primes
			if (ctl_wr)
				primed <= 1'b0;
			else if (snapshot_done && auto_q && !man_dly[1])
				primed <= 1'b1;
		end
	end
	chk_man_refresh: assert property (
		man_rise |-> ##2 snapshot_done)
		else $error("no refresh after manual trigger");
	chk_done_cause: assert property (
		snapshot_done |-> auto_q || $past(auto_q) || $past(man_rise, 2))
		else $error("refresh without a trigger");
	chk_auto_period: assert property (
		auto_q && primed && since == AUTO_CYCLES - 1 |-> snapshot_done)
		else $error("timed refresh missing");
	chk_auto_early: assert property (
		snapshot_done && primed |-> since == AUTO_CYCLES - 1)
		else $error("timed refresh early");
	chk_crc_high: assert property (
		rd && paddr == 8'h04 |-> (prdata & ~32'h30) == 32'h0)
		else $error("crc4 high byte layout");
	chk_frame_high: assert property (
		rd && paddr == 8'h0c |-> (prdata & ~32'hf) == 32'h0)
		else $error("framing high byte layout");
	chk_align_bits: assert property (
		rd && paddr == 8'h10 |-> (prdata & ~32'h7) == 32'h0)
		else $error("align change layout");
	chk_loss_bits: assert property (
		rd && paddr == 8'h14 |-> (prdata & ~32'hf) == 32'h0)
		else $error("frame loss layout");
	chk_ro_write: assert property (
		ack && pwrite && paddr < 8'h40 |-> pslverr)
		else $error("snapshot write not refused");
endmodule : ecs_snapshot_bank_props

bind ecs_snapshot_bank ecs_snapshot_bank_props #(
	.AUTO_CYCLES(AUTO_CYCLES)
) i_props (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .events, .snapshot_done);

// file: test/ecs_snapshot_bank_tb_top.sv
// Purpose: directed bench for the error counter snapshot bank
// Assumes: short timed period so timed refreshes fit the run
// Notes: expected bytes follow the counter widths, saturating
`timescale 1ns/100ps
`define CHK(nm, e, s) begin \
	checks++; \
	if ((e) !== (s)) begin \
		n_fail++; \
		$display("mismatch %s exp %h got %h", nm, e, s); \
	end \
end
module ecs_snapshot_bank_tb_top;
	import ecs_pkg::*;
	localparam longint AUTO = 20;
	logic clk;
	logic rst_n;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic snapshot_done;
	ecs_events_s events;
	int n_fail;
	int checks;
	int t;
	logic [31:0] r;
	logic err;
	ecs_snapshot_bank #(.AUTO_CYCLES(AUTO)) i_dut (.clk, .rst_n, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.events, .snapshot_done);
	// clock, 10 ns period
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic complete_run;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run
	// one apb transfer; request held until pready is seen
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic x);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) begin
			n_fail++;
			complete_run();
		end
		q = prdata;
		x = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_done(input int lim, output int d);
		d = -1;
		for (int k = 1; k <= lim && d < 0; k++) begin
			@(posedge clk);
			if (snapshot_done === 1'b1)
				d = k;
		end
	endtask : wait_done
	task automatic pulse(input int n, input ecs_events_s m);
		@(posedge clk);
		events <= m;
		repeat (n) @(posedge clk);
		events <= '0;
	endtask : pulse
	// saturated count of n events, placed as register i shows it
	function automatic logic [7:0] exp_reg(input int i, input int n);
		int w;
		logic [15:0] v;
		case (i)
			2, 3: w = W_FRAMING;
			4: w = W_ALIGN;
			5: w = W_FRAME_LOSS;
			6, 7, 8, 9: w = W_PATTERN;
			default: w = W_CRC4;
		endcase
		v = 16'(n > (1 << w) - 1 ? (1 << w) - 1 : n);
		if (w < 8 || i % 2 == 0)
			return v[7:0];
		if (w == W_CRC4)
			return {2'h0, v[9:8], 4'h0};
		return v[15:8];
	endfunction : exp_reg
	task automatic check_all(input int n);
		for (int i = 0; i < 16; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0, r, err);
			`CHK("snap", {24'h0, exp_reg(i, n)}, r)
			`CHK("snap err", 1'b0, err)
		end
	endtask : check_all
	task automatic scn_reset;
		apb(1'b1, 8'h00, 32'hff, r, err);
		`CHK("ro write", 1'b1, err)
		check_all(0);
		apb(1'b0, 8'h40, 32'h0, r, err);
		`CHK("ctl reset", 32'h0, r)
		apb(1'b0, 8'h44, 32'h0, r, err);
		`CHK("unmapped", 1'b1, err)
	endtask : scn_reset
	task automatic scn_manual;
		pulse(300, '1);
		apb(1'b1, 8'h40, 32'h2, r, err);
		`CHK("ctl wr err", 1'b0, err)
		wait_done(8, t);
		`CHK("manual done", 2, t)
		check_all(300);
	endtask : scn_manual
	task automatic scn_hold;
		pulse(5, '1);
		apb(1'b1, 8'h40, 32'h2, r, err);
		wait_done(8, t);
		`CHK("no rise", -1, t)
		check_all(300);
		apb(1'b1, 8'h40, 32'h0, r, err);
		apb(1'b1, 8'h40, 32'h2, r, err);
		wait_done(8, t);
		`CHK("rearm done", 2, t)
		check_all(5);
	endtask : scn_hold
	// mid-run reset clears snapshots, counters and control
	task automatic scn_rerst;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		check_all(0);
		apb(1'b0, 8'h40, 32'h0, r, err);
		`CHK("ctl rerst", 32'h0, r)
	endtask : scn_rerst
	// each source counted alone, so swapped wiring shows
	task automatic scn_sources;
		int s;
		for (int j = 0; j < N_EVENTS; j++)
			pulse(j + 1, 9'(1 << (N_EVENTS - 1 - j)));
		apb(1'b1, 8'h40, 32'h0, r, err);
		apb(1'b1, 8'h40, 32'h2, r, err);
		wait_done(8, t);
		`CHK("src done", 2, t)
		for (int i = 0; i < 16; i++) begin
			s = i < 4 ? i / 2 : (i < 6 ? i - 2 : i / 2 + 1);
			apb(1'b0, 8'(i * 4), 32'h0, r, err);
			`CHK("src snap", {24'h0, exp_reg(i, s + 1)}, r)
		end
	endtask : scn_sources
	task automatic scn_auto;
		apb(1'b1, 8'h40, 32'h1, r, err);
		wait_done(60, t);
		`CHK("auto first", int'(AUTO) + 1, t)
		wait_done(60, t);
		`CHK("auto period", int'(AUTO), t)
		apb(1'b1, 8'h40, 32'h0, r, err);
		repeat (3) @(posedge clk);
		wait_done(60, t);
		`CHK("auto off", -1, t)
	endtask : scn_auto
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		events = '0;
		n_fail = 0;
		checks = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		scn_reset();
		scn_manual();
		scn_hold();
		scn_rerst();
		scn_sources();
		scn_auto();
		complete_run();
	end
endmodule : ecs_snapshot_bank_tb_top
